// ---- cbcs_map.svh ----
`ifndef CBCS_MAP_SVH
`define CBCS_MAP_SVH

// Bus addresses
`define CBCS_RESET_PC 16'h0000
`define CBCS_DUMMY_ADDR 16'hffff

// Prebytes and fixed opcodes
`define CBCS_PREBYTE_PAGE2 8'h18
`define CBCS_PREBYTE_PAGE3 8'h1a
`define CBCS_PREBYTE_PAGE4 8'hcd
`define CBCS_OP_BSR 8'h8d
`define CBCS_OP_JSR_IND 8'had
`define CBCS_REL_COLUMN 4'h2

// Opcode field positions
`define CBCS_COL_MSB 7
`define CBCS_COL_LSB 4
`define CBCS_ACCB_BIT 6
`define CBCS_MODE_MSB 5
`define CBCS_MODE_LSB 4

// Page-one inherent opcodes
`define CBCS_OP_TEST 8'h00
`define CBCS_OP_INTEGER_DIVIDE 8'h02
`define CBCS_OP_FRACTIONAL_DIVIDE 8'h03
`define CBCS_OP_MUL 8'h3d
`define CBCS_OP_WAI 8'h3e
`define CBCS_OP_SWI 8'h3f

// Page two and four second bytes indexed by the Y register
`define CBCS_OP_SUBTRACT_D_Y 8'ha3
`define CBCS_OP_ADD_D_A_Y 8'he3
`define CBCS_OP_CMP16_Y 8'hac
`define CBCS_OP_STD_Y 8'hed
`define CBCS_OP_STY_Y 8'hef
`define CBCS_OP_STS_Y 8'haf
`define CBCS_OP_BIT_SET_OP_Y 8'h1c
`define CBCS_OP_BIT_CLEAR_OP_Y 8'h1d
`define CBCS_OP_BRANCH_IF_BITS_SET_Y 8'h1e
`define CBCS_OP_BRANCH_IF_BITS_CLEAR_Y 8'h1f

// Program counter steps
`define CBCS_STEP_OFFS 16'h0002
`define CBCS_STEP_NEXT3 16'h0003
`define CBCS_STEP_MASK 16'h0003
`define CBCS_STEP_BROFF 16'h0004
`define CBCS_STEP_BRNEXT 16'h0005
`define CBCS_STEP_REL 16'h0002

`endif

// ---- cbcs_pkg.sv ----
package cbcs_pkg;

    typedef enum logic [3:0] {
        ST_FETCH = 4'h0, ST_PRE2 = 4'h1, ST_OFFS = 4'h3, ST_DUM1 = 4'h2,
        ST_OPHI = 4'h6, ST_OPLO = 4'h7, ST_DEND = 4'h5, ST_MASK = 4'h4,
        ST_DMID = 4'hc, ST_RESULT = 4'hd, ST_BRO2 = 4'hf, ST_TARGET = 4'he,
        ST_PUSHLO = 4'ha, ST_PUSHHI = 4'hb, ST_REL = 4'h9
    } cbcs_state_e;

    typedef enum logic [2:0] {
        CL_NONE, CL_STORE16, CL_ARITH16, CL_JSR, CL_BITSC, CL_BRBIT, CL_READ8
    } cbcs_class_e;

    typedef enum logic [1:0] {PG_ONE, PG_TWO, PG_THREE, PG_FOUR} cbcs_page_e;

    typedef enum logic [1:0] {AM_IMM, AM_DIR, AM_IND, AM_EXT} cbcs_mode_e;

    typedef enum logic [2:0] {
        SP_NONE, SP_TEST, SP_INTEGER_DIVIDE, SP_FRACTIONAL_DIVIDE, SP_MUL, SP_WAI, SP_SWI
    } cbcs_special_e;

endpackage

// ---- cbcs_sequencer.sv ----
`timescale 1ns/100ps
`include "cbcs_map.svh"
// Notes on behaviour
// - Y-indexed 16-bit stores take 6 cycles, writing high byte at EA then low at EA+1.
// - Every Y-indexed form reads prebyte, second opcode, offset, then one dummy read.
// - Y-indexed 16-bit add, compare and subtract take 7 cycles, ending on a $FFFF read.
// - Sixteen-bit operands are big-endian, high byte at EA and low byte at EA+1.
// - The Y-indexed subroutine jump takes 7 cycles ending in two stack writes.
// - A subroutine call reads the target address before pushing the return address.
// - The return address is pushed low byte at SP, then high byte at SP-1, both writes.
// - The relative subroutine branch $8D takes 6 cycles with a $FFFF dummy third.
// - High nibble is the column, 8-B select A, C-F select B, modes imm/dir/ind/ext.
// - Codes $18, $1A and $CD are prebytes for pages 2, 3 and 4 and fetch another byte.
// - Test, divides, multiply, wait and software interrupt decode at their map places.
module cbcs_sequencer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] dataIn,
    input wire logic [15:0] indexY,
    input wire logic [15:0] stackPtr,
    input wire logic [15:0] storeData,
    input wire logic [7:0] resultByte,
    input wire logic branchTaken,
    output logic [15:0] busAddr,
    output logic busRnw,
    output logic [7:0] busDataOut,
    output logic [1:0] pageSel,
    output logic accGroup,
    output logic accSelB,
    output logic [1:0] addrModeSel,
    output logic [2:0] specialOp
);
    cbcs_pkg::cbcs_state_e stateQ, stateD;
    cbcs_pkg::cbcs_class_e clsQ, clsD;
    cbcs_pkg::cbcs_page_e pageQ, pageD;
    logic [15:0] addrQ, addrD, eaQ, eaD, pcQ, pcD, retQ, retD, nextQ, nextD;
    logic [7:0] doutQ, doutD, opQ, opD;
    logic rnwQ, rnwD, bsrQ, bsrD;
    function automatic logic [15:0] relTarget(input logic [15:0] base, input logic [7:0] off);
        relTarget = base + {{8{off[7]}}, off};
    endfunction
    function automatic cbcs_pkg::cbcs_class_e classOf(input cbcs_pkg::cbcs_page_e pg,
                                                      input logic [7:0] op);
        classOf = cbcs_pkg::CL_NONE;
        if (pg == cbcs_pkg::PG_TWO || pg == cbcs_pkg::PG_FOUR) begin
            if (op == `CBCS_OP_STD_Y || op == `CBCS_OP_STY_Y || op == `CBCS_OP_STS_Y) begin
                classOf = cbcs_pkg::CL_STORE16;
            end else if (op == `CBCS_OP_SUBTRACT_D_Y || op == `CBCS_OP_ADD_D_A_Y || op == `CBCS_OP_CMP16_Y) begin
                classOf = cbcs_pkg::CL_ARITH16;
            end else if (op == `CBCS_OP_JSR_IND) begin
                classOf = cbcs_pkg::CL_JSR;
            end else if (op == `CBCS_OP_BIT_SET_OP_Y || op == `CBCS_OP_BIT_CLEAR_OP_Y) begin
                classOf = cbcs_pkg::CL_BITSC;
            end else if (op == `CBCS_OP_BRANCH_IF_BITS_SET_Y || op == `CBCS_OP_BRANCH_IF_BITS_CLEAR_Y) begin
                classOf = cbcs_pkg::CL_BRBIT;
            end else if (op[7:4] == 4'h6 || op[7:4] == 4'ha || op[7:4] == 4'he) begin
                classOf = cbcs_pkg::CL_READ8;
            end
        end
    endfunction
    always_comb begin
        stateD = stateQ;
        addrD = addrQ;
        rnwD = 1'b1;
        doutD = doutQ;
        opD = opQ;
        pageD = pageQ;
        clsD = clsQ;
        bsrD = bsrQ;
        eaD = eaQ;
        pcD = pcQ;
        retD = retQ;
        nextD = nextQ;
        case (stateQ)
            cbcs_pkg::ST_FETCH: begin
                opD = dataIn;
                pcD = addrQ;
                pageD = cbcs_pkg::PG_ONE;
                clsD = cbcs_pkg::CL_NONE;
                bsrD = (dataIn == `CBCS_OP_BSR);
                addrD = addrQ + 16'h0001;
                if (dataIn == `CBCS_PREBYTE_PAGE2) begin
                    pageD = cbcs_pkg::PG_TWO;
                    stateD = cbcs_pkg::ST_PRE2;
                end else if (dataIn == `CBCS_PREBYTE_PAGE3) begin
                    pageD = cbcs_pkg::PG_THREE;
                    stateD = cbcs_pkg::ST_PRE2;
                end else if (dataIn == `CBCS_PREBYTE_PAGE4) begin
                    pageD = cbcs_pkg::PG_FOUR;
                    stateD = cbcs_pkg::ST_PRE2;
                end else if (dataIn[`CBCS_COL_MSB:`CBCS_COL_LSB] == `CBCS_REL_COLUMN
                             || dataIn == `CBCS_OP_BSR) begin
                    stateD = cbcs_pkg::ST_REL;
                end
            end
            cbcs_pkg::ST_PRE2: begin
                opD = dataIn;
                clsD = classOf(pageQ, dataIn);
                addrD = pcQ + `CBCS_STEP_OFFS;
                stateD = (clsD == cbcs_pkg::CL_NONE) ? cbcs_pkg::ST_FETCH : cbcs_pkg::ST_OFFS;
            end
            cbcs_pkg::ST_OFFS: begin
                eaD = indexY + {8'h00, dataIn};
                retD = pcQ + `CBCS_STEP_NEXT3;
                nextD = pcQ + `CBCS_STEP_NEXT3;
                addrD = `CBCS_DUMMY_ADDR;
                stateD = cbcs_pkg::ST_DUM1;
            end
            cbcs_pkg::ST_DUM1: begin
                addrD = eaQ;
                if (clsQ == cbcs_pkg::CL_JSR) begin
                    stateD = cbcs_pkg::ST_TARGET;
                end else begin
                    stateD = cbcs_pkg::ST_OPHI;
                    if (clsQ == cbcs_pkg::CL_STORE16) begin
                        rnwD = 1'b0;
                        doutD = storeData[15:8];
                    end
                end
            end
            cbcs_pkg::ST_OPHI: begin
                if (clsQ == cbcs_pkg::CL_STORE16) begin
                    stateD = cbcs_pkg::ST_OPLO;
                    addrD = eaQ + 16'h0001;
                    rnwD = 1'b0;
                    doutD = storeData[7:0];
                end else if (clsQ == cbcs_pkg::CL_ARITH16) begin
                    stateD = cbcs_pkg::ST_OPLO;
                    addrD = eaQ + 16'h0001;
                end else if (clsQ == cbcs_pkg::CL_BITSC || clsQ == cbcs_pkg::CL_BRBIT) begin
                    stateD = cbcs_pkg::ST_MASK;
                    addrD = pcQ + `CBCS_STEP_MASK;
                end else begin
                    stateD = cbcs_pkg::ST_FETCH;
                    addrD = nextQ;
                end
            end
            cbcs_pkg::ST_OPLO: begin
                if (clsQ == cbcs_pkg::CL_STORE16) begin
                    stateD = cbcs_pkg::ST_FETCH;
                    addrD = nextQ;
                end else begin
                    stateD = cbcs_pkg::ST_DEND;
                    addrD = `CBCS_DUMMY_ADDR;
                end
            end
            cbcs_pkg::ST_MASK: begin
                if (clsQ == cbcs_pkg::CL_BITSC) begin
                    stateD = cbcs_pkg::ST_DMID;
                    addrD = `CBCS_DUMMY_ADDR;
                end else begin
                    stateD = cbcs_pkg::ST_BRO2;
                    addrD = pcQ + `CBCS_STEP_BROFF;
                end
            end
            cbcs_pkg::ST_DMID: begin
                stateD = cbcs_pkg::ST_RESULT;
                addrD = eaQ;
                rnwD = 1'b0;
                doutD = resultByte;
                nextD = pcQ + `CBCS_STEP_BROFF;
            end
            cbcs_pkg::ST_BRO2: begin
                nextD = branchTaken ? relTarget(pcQ + `CBCS_STEP_BRNEXT, dataIn)
                                    : pcQ + `CBCS_STEP_BRNEXT;
                stateD = cbcs_pkg::ST_DEND;
                addrD = `CBCS_DUMMY_ADDR;
            end
            cbcs_pkg::ST_REL: begin
                nextD = (bsrQ || branchTaken) ? relTarget(pcQ + `CBCS_STEP_REL, dataIn)
                                              : pcQ + `CBCS_STEP_REL;
                retD = pcQ + `CBCS_STEP_REL;
                stateD = cbcs_pkg::ST_DEND;
                addrD = `CBCS_DUMMY_ADDR;
            end
            cbcs_pkg::ST_DEND: begin
                addrD = nextQ;
                stateD = bsrQ ? cbcs_pkg::ST_TARGET : cbcs_pkg::ST_FETCH;
            end
            cbcs_pkg::ST_TARGET: begin
                if (clsQ == cbcs_pkg::CL_JSR) begin
                    nextD = eaQ;
                end
                stateD = cbcs_pkg::ST_PUSHLO;
                addrD = stackPtr;
                rnwD = 1'b0;
                doutD = retQ[7:0];
            end
            cbcs_pkg::ST_PUSHLO: begin
                stateD = cbcs_pkg::ST_PUSHHI;
                addrD = stackPtr - 16'h0001;
                rnwD = 1'b0;
                doutD = retQ[15:8];
            end
            cbcs_pkg::ST_RESULT, cbcs_pkg::ST_PUSHHI: begin
                stateD = cbcs_pkg::ST_FETCH;
                addrD = nextQ;
            end
            default: begin
                stateD = cbcs_pkg::ST_FETCH;
                addrD = `CBCS_RESET_PC;
            end
        endcase
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stateQ <= cbcs_pkg::ST_FETCH;
            addrQ <= `CBCS_RESET_PC;
            rnwQ <= 1'b1;
            doutQ <= 8'h00;
            opQ <= 8'h00;
            pageQ <= cbcs_pkg::PG_ONE;
            clsQ <= cbcs_pkg::CL_NONE;
            bsrQ <= 1'b0;
            eaQ <= 16'h0000;
            pcQ <= 16'h0000;
            retQ <= 16'h0000;
            nextQ <= 16'h0000;
        end else begin
            stateQ <= stateD;
            addrQ <= addrD;
            rnwQ <= rnwD;
            doutQ <= doutD;
            opQ <= opD;
            pageQ <= pageD;
            clsQ <= clsD;
            bsrQ <= bsrD;
            eaQ <= eaD;
            pcQ <= pcD;
            retQ <= retD;
            nextQ <= nextD;
        end
    end
    assign busAddr = addrQ;
    assign busRnw = rnwQ;
    assign busDataOut = doutQ;
    assign pageSel = pageQ;
    assign accGroup = opQ[`CBCS_COL_MSB] && (pageQ == cbcs_pkg::PG_ONE);
    assign accSelB = opQ[`CBCS_ACCB_BIT];
    assign addrModeSel = opQ[`CBCS_MODE_MSB:`CBCS_MODE_LSB];
    always_comb begin
        specialOp = cbcs_pkg::SP_NONE;
        if (pageQ == cbcs_pkg::PG_ONE) begin
            case (opQ)
                `CBCS_OP_TEST: specialOp = cbcs_pkg::SP_TEST;
                `CBCS_OP_INTEGER_DIVIDE: specialOp = cbcs_pkg::SP_INTEGER_DIVIDE;
                `CBCS_OP_FRACTIONAL_DIVIDE: specialOp = cbcs_pkg::SP_FRACTIONAL_DIVIDE;
                `CBCS_OP_MUL: specialOp = cbcs_pkg::SP_MUL;
                `CBCS_OP_WAI: specialOp = cbcs_pkg::SP_WAI;
                `CBCS_OP_SWI: specialOp = cbcs_pkg::SP_SWI;
                default: specialOp = cbcs_pkg::SP_NONE;
            endcase
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_offset_then_dummy: assert property (
        stateQ == cbcs_pkg::ST_OFFS |=> busAddr == 16'hffff && busRnw
    ) else $error("dummy read missing after index offset");
    a_store_hi_lo: assert property (
        stateQ == cbcs_pkg::ST_OPHI && clsQ == cbcs_pkg::CL_STORE16 |-> !busRnw
        ##1 (!busRnw && busAddr == $past(busAddr) + 16'h0001)
        ##1 (stateQ == cbcs_pkg::ST_FETCH)
    ) else $error("16-bit store sequence wrong");
    a_arith_tail: assert property (
        stateQ == cbcs_pkg::ST_OPLO && clsQ == cbcs_pkg::CL_ARITH16
        |-> busRnw && busAddr == eaQ + 16'h0001 ##1 busAddr == 16'hffff && busRnw
    ) else $error("16-bit operand read tail wrong");
    a_prebyte_fetch: assert property (
        stateQ == cbcs_pkg::ST_FETCH && dataIn == 8'h18
        |=> stateQ == cbcs_pkg::ST_PRE2 && busAddr == $past(busAddr) + 16'h0001
    ) else $error("prebyte not followed by opcode fetch");
    a_call_order: assert property (
        stateQ == cbcs_pkg::ST_TARGET |-> busRnw ##1 !busRnw ##1 !busRnw
        ##1 (busRnw && stateQ == cbcs_pkg::ST_FETCH)
    ) else $error("subroutine call cycles out of order");
    a_push_order: assert property (
        stateQ == cbcs_pkg::ST_PUSHLO |=> busAddr == $past(busAddr) - 16'h0001
        && busDataOut == retQ[15:8]
    ) else $error("return address push order wrong");
    a_branch_three: assert property (
        stateQ == cbcs_pkg::ST_REL && !bsrQ |=> busAddr == 16'hffff
        ##1 stateQ == cbcs_pkg::ST_FETCH && busAddr == nextQ
    ) else $error("relative branch not three cycles");
    a_bsr_six: assert property (
        stateQ == cbcs_pkg::ST_FETCH && dataIn == 8'h8d
        |=> stateQ == cbcs_pkg::ST_REL ##1 busAddr == 16'hffff
        ##1 stateQ == cbcs_pkg::ST_TARGET ##3 stateQ == cbcs_pkg::ST_FETCH
    ) else $error("relative subroutine branch not six cycles");
    a_bit_result: assert property (
        stateQ == cbcs_pkg::ST_MASK && clsQ == cbcs_pkg::CL_BITSC
        |=> busAddr == 16'hffff ##1 (!busRnw && busAddr == eaQ)
    ) else $error("bit result write misplaced");
endmodule

// ---- cbcs_bus_memory.sv ----
`timescale 1ns/100ps
module cbcs_bus_memory (
    input wire logic mclk,
    input wire logic [15:0] busAddr,
    input wire logic busRnw,
    input wire logic [7:0] busDataOut,
    output logic [7:0] dataIn
);
    logic [7:0] store [0:65535];

    // Unused bytes hold a one-cycle opcode so stray fetches stay harmless
    initial begin
        for (int i = 0; i < 65536; i++) begin
            store[i] = 8'h01;
        end
    end

    // Same-cycle read of the addressed byte
    assign dataIn = store[busAddr];

    // A write lands at the edge that ends its bus cycle
    always @(posedge mclk) begin
        if (busRnw === 1'b0) begin
            store[busAddr] <= busDataOut;
        end
    end
endmodule

// ---- tb_cpu_bus_cycle_sequencer.sv ----
`timescale 1ns/100ps
module tb_cpu_bus_cycle_sequencer;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] indexY = 16'h0000;
    logic [15:0] stackPtr = 16'h01ff;
    logic [15:0] storeData = 16'h0000;
    logic [7:0] resultByte = 8'h00;
    logic branchTaken = 1'b0;
    logic [7:0] dataIn;
    logic [7:0] busDataOut;
    logic [15:0] busAddr;
    logic busRnw;
    logic accGroup;
    logic accSelB;
    logic [1:0] pageSel;
    logic [1:0] addrModeSel;
    logic [2:0] specialOp;
    int failCount = 0;
    int checked = 0;
    int cycles = 0;
    logic [24:0] expQ[$];

    always #50 mclk = ~mclk;

    cbcs_sequencer DUT (
        .mclk(mclk), .rst(rst), .dataIn(dataIn), .indexY(indexY), .stackPtr(stackPtr),
        .storeData(storeData), .resultByte(resultByte), .branchTaken(branchTaken),
        .busAddr(busAddr), .busRnw(busRnw), .busDataOut(busDataOut), .pageSel(pageSel),
        .accGroup(accGroup), .accSelB(accSelB), .addrModeSel(addrModeSel),
        .specialOp(specialOp)
    );
    cbcs_bus_memory mem (
        .mclk(mclk), .busAddr(busAddr), .busRnw(busRnw), .busDataOut(busDataOut),
        .dataIn(dataIn)
    );

    function automatic logic [24:0] rd(input logic [15:0] a);
        return {1'b1, a, 8'h00};
    endfunction

    function automatic logic [24:0] wr(input logic [15:0] a, input logic [7:0] d);
        return {1'b0, a, d};
    endfunction

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic checkVal(input string what, input logic [15:0] want, input logic [15:0] got);
        checked++;
        if (got !== want) begin
            failCount++;
            $display("unexpected %s: expected %h, seen %h", what, want, got);
        end
    endtask

    task automatic checkBus(input logic [24:0] want);
        checked++;
        if (busRnw !== want[24] || busAddr !== want[23:8]
            || (!want[24] && busDataOut !== want[7:0])) begin
            failCount++;
            $display("unexpected bus cycle: expected %h, seen %h", want,
                {busRnw, busAddr, busDataOut});
        end
    endtask

    // Holds the core in reset and loads the first three program bytes
    task automatic startProg(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
        @(posedge mclk);
        #10 rst = 1'b1;
        mem.store[0] = b0;
        mem.store[1] = b1;
        mem.store[2] = b2;
    endtask

    task automatic yHead();
        expQ = '{rd(16'h0000), rd(16'h0001), rd(16'h0002), rd(16'hffff)};
    endtask

    // Releases reset and follows the expected bus cycles one clock each
    task automatic runSeq(input string name, input logic [1:0] pg);
        @(posedge mclk);
        #10 rst = 1'b0;
        foreach (expQ[i]) begin
            @(negedge mclk);
            checkBus(expQ[i]);
            if (i == 3) begin
                checkVal("page select", 16'(pg), 16'(pageSel));
            end
        end
        $display("test %s done", name);
    endtask

    task automatic testStore16();
        logic [15:0] ops [4] = '{16'h18ed, 16'h18ef, 16'h18af, 16'hcdef};
        for (int i = 0; i < 4; i++) begin
            startProg(ops[i][15:8], ops[i][7:0], 8'hff);
            indexY = 16'h2f00 + 16'(i);
            storeData = 16'ha1b2 + 16'(i);
            yHead();
            expQ = {expQ, wr(indexY + 16'h00ff, storeData[15:8]),
                wr(indexY + 16'h0100, storeData[7:0]), rd(16'h0003)};
            runSeq("store16", ops[i][15] ? 2'h3 : 2'h1);
        end
    endtask

    task automatic testArith16();
        logic [15:0] ops [4] = '{16'h18a3, 16'h18e3, 16'h18ac, 16'hcdac};
        for (int i = 0; i < 4; i++) begin
            startProg(ops[i][15:8], ops[i][7:0], 8'h00);
            indexY = 16'h10ff;
            yHead();
            expQ = {expQ, rd(16'h10ff), rd(16'h1100), rd(16'hffff), rd(16'h0003)};
            runSeq("arith16", ops[i][15] ? 2'h3 : 2'h1);
        end
    endtask

    task automatic testJsr();
        startProg(8'h18, 8'had, 8'h10);
        indexY = 16'h3000;
        stackPtr = 16'h01ff;
        yHead();
        expQ = {expQ, rd(16'h3010), wr(16'h01ff, 8'h03), wr(16'h01fe, 8'h00), rd(16'h3010)};
        runSeq("jsr", 2'h1);
    endtask

    task automatic testBsr();
        startProg(8'h8d, 8'h20, 8'h01);
        stackPtr = 16'h0100;
        expQ = '{rd(16'h0000), rd(16'h0001), rd(16'hffff), rd(16'h0022),
            wr(16'h0100, 8'h02), wr(16'h00ff, 8'h00), rd(16'h0022)};
        runSeq("bsr", 2'h0);
    endtask

    task automatic testBranch();
        for (int t = 0; t < 2; t++) begin
            startProg(t ? 8'h20 : 8'h27, 8'hf0, 8'h01);
            branchTaken = 1'(t);
            expQ = '{rd(16'h0000), rd(16'h0001), rd(16'hffff), rd(t ? 16'hfff2 : 16'h0002)};
            runSeq("branch", 2'h0);
        end
    endtask

    task automatic testBitOps();
        for (int i = 0; i < 2; i++) begin
            startProg(8'h18, 8'h1c + 8'(i), 8'h04);
            indexY = 16'h4000;
            resultByte = 8'h5a + 8'(i);
            yHead();
            expQ = {expQ, rd(16'h4004), rd(16'h0003), rd(16'hffff),
                wr(16'h4004, resultByte), rd(16'h0004)};
            runSeq("bitop", 2'h1);
        end
    endtask

    task automatic testBitBranch();
        for (int i = 0; i < 2; i++) begin
            startProg(8'h18, 8'h1e + 8'(i), 8'h04);
            mem.store[4] = 8'h08;
            indexY = 16'h4000;
            branchTaken = (i == 0);
            yHead();
            expQ = {expQ, rd(16'h4004), rd(16'h0003), rd(16'h0004), rd(16'hffff),
                rd(i ? 16'h0005 : 16'h000d)};
            runSeq("bitbranch", 2'h1);
        end
    endtask

    task automatic testPage3();
        startProg(8'h1a, 8'h55, 8'h01);
        expQ = '{rd(16'h0000), rd(16'h0001), rd(16'h0002), rd(16'h0003)};
        runSeq("page3", 2'h0);
    endtask

    task automatic testDecode();
        logic [7:0] ops [13] = '{8'h8b, 8'h9b, 8'hab, 8'hbb, 8'hcb, 8'hfb, 8'h00, 8'h02,
            8'h03, 8'h3d, 8'h3e, 8'h3f, 8'h01};
        logic [2:0] spc [13] = '{0, 0, 0, 0, 0, 0, 1, 2, 3, 4, 5, 6, 0};
        logic [3:0] col;
        for (int i = 0; i < 13; i++) begin
            startProg(ops[i], 8'h01, 8'h01);
            col = ops[i][7:4] - (ops[i][6] ? 4'hc : 4'h8);
            @(posedge mclk);
            #10 rst = 1'b0;
            repeat (2) @(negedge mclk);
            checkVal("operand group", 16'(ops[i][7]), 16'(accGroup));
            checkVal("special op", 16'(spc[i]), 16'(specialOp));
            if (ops[i][7]) begin
                checkVal("acc select", 16'(ops[i][6]), 16'(accSelB));
                checkVal("address mode", 16'(col[1:0]), 16'(addrModeSel));
            end
        end
        $display("test decode done");
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 1000) begin
            failCount++;
            $display("timeout after %0d cycles", cycles);
            summarize();
        end
    end

    initial begin
        repeat (16) @(posedge mclk);
        testStore16();
        testArith16();
        testJsr();
        testBsr();
        testBranch();
        testBitOps();
        testBitBranch();
        testPage3();
        testDecode();
        summarize();
    end
endmodule
